/* File: hw/lac_cfg.svh */
// constants for the capture and storage qualifier block
`ifndef LAC_CFG_SVH
`define LAC_CFG_SVH

`define LAC_PCT_FULL    100
`define LAC_PCT_BIG     88
`define LAC_PCT_HALF    50
`define LAC_PCT_SMALL   12

`define LAC_CNT_W       16
`define LAC_NCTR        2
`define LAC_NFLAG       4
`define LAC_FST_W       4
`define LAC_IDX_W       17

`define LAC_CTR_INIT    16'h0000
`define LAC_FLAG_INIT   4'h0
`define LAC_FST_FIRST   4'h0
`define LAC_IDX_ZERO    17'h00000

`define LAC_ST_IDLE     3'h1
`define LAC_ST_RUN      3'h2
`define LAC_ST_DONE     3'h4

`define LAC_POS_POSTMOST 2'h0
`define LAC_POS_CENTER   2'h1
`define LAC_POS_PREMOST  2'h2

`endif

/* File: hw/lac_pkg.sv */
// types for the capture and storage qualifier block
`include "lac_cfg.svh"

package lac_pkg;

	typedef enum logic [1:0] {
		LAC_POS_POSTMOST = `LAC_POS_POSTMOST,
		LAC_POS_CENTER   = `LAC_POS_CENTER,
		LAC_POS_PREMOST  = `LAC_POS_PREMOST
	} lac_pos_t;

	typedef enum logic [2:0] {
		LAC_IDLE = `LAC_ST_IDLE,
		LAC_RUN  = `LAC_ST_RUN,
		LAC_DONE = `LAC_ST_DONE
	} lac_acq_t;

	typedef struct packed {
		logic     qual_state;
		logic     segmented;
		lac_pos_t pos_rt;
		lac_pos_t pos_pu;
		logic     pu_en;
	} lac_cfg_t;

	typedef struct packed {
		logic                  begin_store;
		logic                  halt_store;
		logic                  trigger;
		logic                  seg_end;
		logic                  has_count;
		logic [`LAC_IDX_W-1:0] count;
		logic                  goto_en;
		logic [`LAC_FST_W-1:0] goto_state;
		logic [`LAC_NCTR-1:0]  ctr_inc;
		logic [`LAC_NCTR-1:0]  ctr_dec;
		logic [`LAC_NCTR-1:0]  ctr_rst;
		logic [`LAC_NFLAG-1:0] flag_set;
		logic [`LAC_NFLAG-1:0] flag_clr;
	} lac_act_t;

	typedef struct packed {
		logic                  running;
		logic                  triggered;
		logic                  paused;
		logic                  done;
		logic                  pu_run;
		logic                  store_on;
		logic [`LAC_FST_W-1:0] flow_state;
		logic [`LAC_NFLAG-1:0] flags;
		logic [`LAC_IDX_W-1:0] trig_index;
	} lac_status_t;

endpackage

/* File: hw/lac_post_calc.sv */
// preset trigger position to post-fill sample count
`timescale 1ns/100ps
`default_nettype none
`include "lac_cfg.svh"

module lac_post_calc (
	input  wire lac_pkg::lac_pos_t     i_pos,
	input  wire logic [`LAC_IDX_W-1:0] i_depth,
	output logic [`LAC_IDX_W-1:0]      o_post
);
	import lac_pkg::*;

	logic [`LAC_IDX_W+7:0] prod;

	always_comb begin
		case (i_pos)
			LAC_POS_POSTMOST: prod = i_depth * (`LAC_IDX_W+8)'(`LAC_PCT_BIG);
			LAC_POS_CENTER:   prod = i_depth * (`LAC_IDX_W+8)'(`LAC_PCT_HALF);
			default:          prod = i_depth * (`LAC_IDX_W+8)'(`LAC_PCT_SMALL);
		endcase
		// same ratios serve the whole buffer or one segment
		o_post = `LAC_IDX_W'(prod / (`LAC_IDX_W+8)'(`LAC_PCT_FULL));
	end

endmodule // lac_post_calc
`default_nettype wire

/* File: hw/lac_flow_ctr.sv */
// one trigger-flow counter resource
`timescale 1ns/100ps
`default_nettype none
`include "lac_cfg.svh"

module lac_flow_ctr (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_b,
	input  wire logic                  i_clr,
	input  wire logic                  i_en,
	input  wire logic                  i_inc,
	input  wire logic                  i_dec,
	input  wire logic                  i_reset,
	output logic [`LAC_CNT_W-1:0]      o_cnt
);
	import lac_pkg::*;

	logic [`LAC_CNT_W-1:0] next_cnt;

	always_comb begin
		next_cnt = o_cnt;
		if (i_clr) begin
			next_cnt = `LAC_CTR_INIT;
		end else if (i_en) begin
			// evaluated on every sample
			if (i_reset) begin
				next_cnt = `LAC_CTR_INIT;
			end else if (i_inc) begin
				next_cnt = o_cnt + `LAC_CNT_W'(1);
			end else if (i_dec) begin
				next_cnt = o_cnt - `LAC_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cnt <= `LAC_CTR_INIT;
		end else begin
			o_cnt <= next_cnt;
		end
	end

endmodule // lac_flow_ctr
`default_nettype wire

/* File: hw/lac_top.sv */
// acquisition control: storage qualifier, trigger position, power-up arm
`timescale 1ns/100ps
`default_nettype none
`include "lac_cfg.svh"

module lac_top #(
	parameter int SAMPLE_W   = 8,
	parameter int DEPTH_LOG2 = 6,
	parameter int SEG_LOG2   = 2
) (
	input  wire logic                                  i_sys_clk,
	input  wire logic                                  i_rst_b,
	input  wire lac_pkg::lac_cfg_t                     i_cfg,
	input  wire logic                                  i_arm,
	input  wire logic                                  i_stop,
	input  wire logic                                  i_smp_en,
	input  wire logic [SAMPLE_W-1:0]                   i_sample,
	input  wire lac_pkg::lac_act_t                     i_act,
	output logic                                       o_wr_en,
	output logic [DEPTH_LOG2-1:0]                      o_wr_addr,
	output logic [SAMPLE_W-1:0]                        o_wr_data,
	output lac_pkg::lac_status_t                       o_status,
	output logic [`LAC_NCTR-1:0][`LAC_CNT_W-1:0]       o_ctr
);
	import lac_pkg::*;

	localparam int SEGW = DEPTH_LOG2 - SEG_LOG2;

	// refuse sizes that the address and index fields cannot hold
	if (SAMPLE_W < 1) begin : g_chk_w
		$error("lac_top: sample width out of range");
	end

	if (DEPTH_LOG2 < 1 || DEPTH_LOG2 >= `LAC_IDX_W) begin : g_chk_d
		$error("lac_top: buffer depth out of range");
	end

	if (SEG_LOG2 < 1 || SEGW < 1) begin : g_chk_s
		$error("lac_top: segment count out of range");
	end

	// depths in samples; index is at least one bit wider than the address so the full depth fits
	localparam logic [`LAC_IDX_W-1:0] FULL_D = `LAC_IDX_W'(1) << DEPTH_LOG2;
	localparam logic [`LAC_IDX_W-1:0] SEG_D  = `LAC_IDX_W'(1) << SEGW;

	// registered state
	lac_acq_t              acq;
	logic                  pu_pend;
	logic                  pu_run;
	logic                  store_on;
	logic                  trig_seen;
	logic                  closing;
	logic [`LAC_IDX_W-1:0] post_left;
	logic [DEPTH_LOG2-1:0] offs;
	logic [SEG_LOG2-1:0]   seg;
	logic [`LAC_FST_W-1:0] fstate;
	logic [`LAC_NFLAG-1:0] flags;
	logic [`LAC_IDX_W-1:0] trig_idx;

	lac_acq_t              next_acq;
	logic                  next_pu_pend;
	logic                  next_pu_run;
	logic                  next_store_on;
	logic                  next_trig_seen;
	logic                  next_closing;
	logic [`LAC_IDX_W-1:0] next_post_left;
	logic [DEPTH_LOG2-1:0] next_offs;
	logic [SEG_LOG2-1:0]   next_seg;
	logic [`LAC_FST_W-1:0] next_fstate;
	logic [`LAC_NFLAG-1:0] next_flags;
	logic [`LAC_IDX_W-1:0] next_trig_idx;
	logic                  next_wr_en;
	logic [DEPTH_LOG2-1:0] next_wr_addr;
	logic [SAMPLE_W-1:0]   next_wr_data;
	lac_status_t           next_status;

	// working signals
	logic                  arm_now;
	logic                  eval;
	logic                  gate_ok;
	logic [`LAC_IDX_W-1:0] depth;
	logic [`LAC_IDX_W-1:0] post_rt;
	logic [`LAC_IDX_W-1:0] post_pu;
	logic [`LAC_IDX_W-1:0] preset;
	logic [DEPTH_LOG2-1:0] seg_mask;

	// power-up arm uses the pending flag caught at reset release
	assign arm_now = i_arm | (pu_pend & i_cfg.pu_en);
	// arm and stop win over a sample taken in the same cycle
	assign eval    = (acq == LAC_RUN) & i_smp_en & ~i_stop & ~arm_now;
	// segmented capture ignores store gating entirely
	assign gate_ok = i_cfg.qual_state & ~i_cfg.segmented;
	assign depth   = i_cfg.segmented ? SEG_D : FULL_D;
	assign seg_mask = i_cfg.segmented ? DEPTH_LOG2'(SEG_D - `LAC_IDX_W'(1))
		: DEPTH_LOG2'(FULL_D - `LAC_IDX_W'(1));
	// power-up run keeps its own position setting
	assign preset  = pu_run ? post_pu : post_rt;

	lac_post_calc u_post_rt (
		.i_pos   (i_cfg.pos_rt),
		.i_depth (depth),
		.o_post  (post_rt)
	);

	lac_post_calc u_post_pu (
		.i_pos   (i_cfg.pos_pu),
		.i_depth (depth),
		.o_post  (post_pu)
	);

	// counter resources, cleared on arming
	for (genvar g = 0; g < `LAC_NCTR; g++) begin : g_ctr
		lac_flow_ctr u_ctr (
			.i_sys_clk (i_sys_clk),
			.i_rst_b   (i_rst_b),
			.i_clr     (arm_now),
			.i_en      (eval),
			.i_inc     (i_act.ctr_inc[g]),
			.i_dec     (i_act.ctr_dec[g]),
			.i_reset   (i_act.ctr_rst[g]),
			.o_cnt     (o_ctr[g])
		);
	end

	always_comb begin
		next_acq       = acq;
		next_pu_pend   = 1'b0;
		next_pu_run    = pu_run;
		next_store_on  = store_on;
		next_trig_seen = trig_seen;
		next_closing   = closing;
		next_post_left = post_left;
		next_offs      = offs;
		next_seg       = seg;
		next_fstate    = fstate;
		next_flags     = flags;
		next_trig_idx  = trig_idx;
		next_wr_en     = 1'b0;
		next_wr_addr   = o_wr_addr;
		next_wr_data   = o_wr_data;
		if (arm_now) begin
			// fresh acquisition
			next_acq       = LAC_RUN;
			next_pu_run    = pu_pend & i_cfg.pu_en;
			// qualifier off or segmented capture means continuous storage; qualifier on in unsegmented capture means wait
			next_store_on  = ~gate_ok;
			next_trig_seen = 1'b0;
			next_closing   = 1'b0;
			next_post_left = `LAC_IDX_ZERO;
			next_offs      = '0;
			next_seg       = '0;
			next_fstate    = `LAC_FST_FIRST;
			next_flags     = `LAC_FLAG_INIT;
			next_trig_idx  = `LAC_IDX_ZERO;
		end else if (acq == LAC_RUN && i_stop) begin
			// host stop forces the trigger and ends, paused or not
			next_acq       = LAC_DONE;
			next_trig_seen = 1'b1;
			next_store_on  = 1'b0;
			if (!trig_seen) begin
				next_trig_idx = `LAC_IDX_W'(offs & seg_mask);
			end
		end else if (eval) begin
			// flow state and flags move on every sample
			if (i_act.goto_en) begin
				next_fstate = i_act.goto_state;
			end
			next_flags = (flags | i_act.flag_set) & ~i_act.flag_clr;
			// gating stays live after the trigger
			if (gate_ok && i_act.begin_store) begin
				next_store_on = 1'b1;
			end else if (gate_ok && i_act.halt_store) begin
				next_store_on = 1'b0;
			end
			if (i_act.trigger && !trig_seen) begin
				// final post-fill: given count or preset
				next_trig_seen = 1'b1;
				next_closing   = 1'b1;
				// an oversize count would wrap the index, so it is clamped
				next_post_left = i_act.has_count ? i_act.count : preset;
				if (next_post_left > depth) begin
					next_post_left = depth;
				end
				next_trig_idx  = depth - next_post_left;
			end else if (i_act.seg_end && i_cfg.segmented && !closing) begin
				// per-segment count, else preset ratio
				next_closing   = 1'b1;
				next_post_left = i_act.has_count ? i_act.count : preset;
				if (next_post_left > depth) begin
					next_post_left = depth;
				end
				next_trig_idx  = depth - next_post_left;
			end
			// a zero count closes without taking this sample
			if (!(next_closing && next_post_left == `LAC_IDX_ZERO) && next_store_on) begin
				// write only while storage is on
				next_wr_en   = 1'b1;
				next_wr_data = i_sample;
				next_wr_addr = i_cfg.segmented
					? ((DEPTH_LOG2'(seg) << SEGW) | (offs & seg_mask))
					: offs;
				next_offs    = (offs + DEPTH_LOG2'(1)) & seg_mask;
				if (next_closing) begin
					next_post_left = next_post_left - `LAC_IDX_W'(1);
				end
			end
			// complete only once the post-fill is stored
			if (next_closing && next_post_left == `LAC_IDX_ZERO) begin
				if (next_trig_seen) begin
					next_acq      = LAC_DONE;
					next_store_on = 1'b0;
				end else begin
					// oldest segment is overwritten when all are used
					next_closing = 1'b0;
					next_seg     = seg + SEG_LOG2'(1);
					next_offs    = '0;
				end
			end
		end
	end

	// output group: status shows the state registered at the same edge
	always_comb begin
		next_status.running    = (next_acq == LAC_RUN);
		next_status.triggered  = next_trig_seen;
		// paused: triggered, post-fill open, storage halted
		next_status.paused     = (next_acq == LAC_RUN) & next_trig_seen & ~next_store_on;
		next_status.done       = (next_acq == LAC_DONE);
		next_status.pu_run     = next_pu_run;
		next_status.store_on   = next_store_on;
		next_status.flow_state = next_fstate;
		next_status.flags      = next_flags;
		next_status.trig_index = next_trig_idx;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acq       <= LAC_IDLE;
			// set at reset so a power-up run arms on the first edge
			pu_pend   <= 1'b1;
			pu_run    <= 1'b0;
			store_on  <= 1'b0;
			trig_seen <= 1'b0;
			closing   <= 1'b0;
			post_left <= `LAC_IDX_ZERO;
			offs      <= '0;
			seg       <= '0;
			fstate    <= `LAC_FST_FIRST;
			flags     <= `LAC_FLAG_INIT;
			trig_idx  <= `LAC_IDX_ZERO;
		end else begin
			acq       <= next_acq;
			pu_pend   <= next_pu_pend;
			pu_run    <= next_pu_run;
			store_on  <= next_store_on;
			trig_seen <= next_trig_seen;
			closing   <= next_closing;
			post_left <= next_post_left;
			offs      <= next_offs;
			seg       <= next_seg;
			fstate    <= next_fstate;
			flags     <= next_flags;
			trig_idx  <= next_trig_idx;
		end
	end

	// ports leave straight from registers, so no glitch reaches the buffer
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wr_en   <= 1'b0;
			o_wr_addr <= '0;
			o_wr_data <= '0;
			o_status  <= '0;
		end else begin
			o_wr_en   <= next_wr_en;
			o_wr_addr <= next_wr_addr;
			o_wr_data <= next_wr_data;
			o_status  <= next_status;
		end
	end

endmodule // lac_top
`default_nettype wire

/* File: tb/lac_top_asserts.sv */
// concurrent checks on the acquisition control ports
`timescale 1ns/100ps
`default_nettype none
`include "lac_cfg.svh"

module lac_top_asserts
	import lac_pkg::*;
#(
	parameter int SAMPLE_W   = 8,
	parameter int DEPTH_LOG2 = 6,
	parameter int SEG_LOG2   = 2
) (
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_rst_b,
	input  wire lac_pkg::lac_cfg_t               i_cfg,
	input  wire logic                            i_arm,
	input  wire logic                            i_stop,
	input  wire logic                            i_smp_en,
	input  wire logic [SAMPLE_W-1:0]             i_sample,
	input  wire lac_pkg::lac_act_t               i_act,
	input  wire logic                            o_wr_en,
	input  wire logic [DEPTH_LOG2-1:0]           o_wr_addr,
	input  wire logic [SAMPLE_W-1:0]             o_wr_data,
	input  wire lac_pkg::lac_status_t            o_status,
	input  wire logic [`LAC_NCTR-1:0][`LAC_CNT_W-1:0] o_ctr
);
	localparam int DEPTH = 1 << DEPTH_LOG2;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// a sample whose actions must be evaluated
	sequence s_taken;
		o_status.running && i_smp_en && !i_arm && !i_stop;
	endsequence
	// same, where begin and halt actions have force
	sequence s_gated;
		s_taken ##0 i_cfg.qual_state && !i_cfg.segmented;
	endsequence
	a_no_early: assert property (s_gated ##0 !o_status.store_on && !i_act.begin_store |=> !o_wr_en)
		else $error("write before begin-store");
	a_begin_wr: assert property (s_gated ##0 i_act.begin_store && !i_act.trigger
		|=> o_wr_en && (o_status.store_on || o_status.done))
		else $error("begin-store did not write");
	a_halt_skip: assert property (s_gated ##0 i_act.halt_store && !i_act.begin_store
		|=> !o_wr_en && !o_status.store_on)
		else $error("halt-store did not stop writes");
	a_seg_open: assert property (s_taken ##0 i_cfg.segmented && !i_act.trigger && !i_act.seg_end
		|=> o_wr_en)
		else $error("segmented sample not written");
	a_arm_clear: assert property (i_arm |=> o_status.running && !o_wr_en && o_status.flow_state == 4'h0
		&& o_status.flags == 4'h0 && o_ctr == '0)
		else $error("arm did not clear state");
	a_wr_cause: assert property (o_wr_en |-> $past(i_smp_en) && $past(o_status.running)
		&& o_wr_data == $past(i_sample))
		else $error("write without a taken sample");
	a_stop_end: assert property (o_status.running && i_stop && !i_arm
		|=> o_status.done && o_status.triggered && !o_status.running)
		else $error("stop did not end run");
	a_flag_set: assert property (s_taken ##0 i_act.flag_set[0] && !i_act.flag_clr[0]
		|=> o_status.flags[0])
		else $error("flag not set");
	a_ctr_step: assert property (s_taken ##0 i_act.ctr_inc[0] && !i_act.ctr_dec[0] && !i_act.ctr_rst[0]
		|=> o_ctr[0] == $past(o_ctr[0]) + 16'h0001)
		else $error("counter did not step");
	a_trig_idx: assert property (s_taken ##0 i_act.trigger && i_act.has_count && !i_cfg.segmented
		&& !o_status.triggered && i_act.count <= DEPTH
		|=> o_status.trig_index == DEPTH - $past(i_act.count))
		else $error("trigger index wrong");
endmodule // lac_top_asserts

bind lac_top lac_top_asserts #(.SAMPLE_W(SAMPLE_W), .DEPTH_LOG2(DEPTH_LOG2), .SEG_LOG2(SEG_LOG2))
	u_asserts (.i_sys_clk, .i_rst_b, .i_cfg, .i_arm, .i_stop, .i_smp_en, .i_sample, .i_act,
	.o_wr_en, .o_wr_addr, .o_wr_data, .o_status, .o_ctr);
`default_nettype wire

/* File: tb/lac_user_model.sv */
// user logic model: sample source for the analyzer
`timescale 1ns/100ps
`default_nettype none

module lac_user_model #(
	parameter int W = 8
) (
	input  wire logic    i_sys_clk,
	input  wire logic    i_rst_b,
	input  wire logic    i_go,
	output logic         o_smp_en,
	output logic [W-1:0] o_sample
);
	logic [W-1:0] cnt;
	// idle shows the inverse so stale data never passes for fresh
	assign o_smp_en = i_go;
	assign o_sample = i_go ? cnt : ~cnt;
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= '0;
		end else if (i_go) begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // lac_user_model
`default_nettype wire

/* File: tb/lac_top_tb.sv */
// self-checking bench for the acquisition control block
`timescale 1ns/100ps
`default_nettype none
`include "lac_cfg.svh"

module lac_top_tb;
	import lac_pkg::*;
	logic                             i_sys_clk;
	logic                             i_rst_b;
	lac_cfg_t                         i_cfg;
	logic                             i_arm;
	logic                             i_stop;
	logic                             i_smp_en;
	logic [7:0]                       i_sample;
	lac_act_t                         i_act;
	logic                             o_wr_en;
	logic [5:0]                       o_wr_addr;
	logic [7:0]                       o_wr_data;
	lac_status_t                      o_status;
	logic [`LAC_NCTR-1:0][`LAC_CNT_W-1:0] o_ctr;
	logic                             go;
	lac_act_t                         nx;
	int                               mismatches;
	int                               comparisons;
	int                               exp_idx[3] = '{8, 32, 57};

	lac_top #(.SAMPLE_W(8), .DEPTH_LOG2(6), .SEG_LOG2(2)) dut (.i_sys_clk, .i_rst_b, .i_cfg,
		.i_arm, .i_stop, .i_smp_en, .i_sample, .i_act, .o_wr_en, .o_wr_addr, .o_wr_data,
		.o_status, .o_ctr);
	lac_user_model u_user (.i_sys_clk, .i_rst_b, .i_go(go), .o_smp_en(i_smp_en), .o_sample(i_sample));

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic lac_act_t fa(input logic b, h, t, s, input int c);
		fa = '0;
		fa.begin_store = b;
		fa.halt_store = h;
		fa.trigger = t;
		fa.seg_end = s;
		fa.has_count = (c >= 0);
		fa.count = c[16:0];
	endfunction
	// outputs of the taken sample are settled at the next falling edge
	task step(input lac_act_t a);
		i_act = a;
		go = 1'b1;
		@(negedge i_sys_clk);
	endtask
	task idle;
		go = 1'b0;
		i_act = '0;
		@(negedge i_sys_clk);
	endtask
	task arm;
		i_arm = 1'b1;
		@(negedge i_sys_clk);
		i_arm = 1'b0;
	endtask
	task do_reset;
		i_rst_b = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		i_rst_b = 1'b1;
	endtask

	task t_walk;
		i_cfg = '0;
		i_cfg.qual_state = 1'b1;
		i_cfg.pos_rt = LAC_POS_CENTER;
		arm();
		chk({o_status.running, o_status.store_on}, 2'b10);
		step(fa(0, 0, 0, 0, -1));
		chk(o_wr_en, 0);
		step(fa(1, 0, 0, 0, -1));
		chk({o_wr_en, o_wr_addr}, {1'b1, 6'h00});
		step(fa(0, 1, 0, 0, -1));
		chk({o_wr_en, o_status.store_on}, 2'b00);
		step(fa(1, 0, 1, 0, 2));
		chk({o_wr_en, o_wr_addr, o_status.triggered, o_status.trig_index}, {8'h83, 17'd62});
		step(fa(0, 0, 0, 0, -1));
		chk({o_wr_en, o_status.done, o_status.running}, 3'b110);
		idle();
		$display("test walk done");
	endtask

	task t_pause;
		arm();
		step(fa(1, 0, 1, 0, 3));
		step(fa(0, 1, 0, 0, -1));
		chk({o_wr_en, o_status.paused}, 2'b01);
		repeat (3) step(fa(0, 0, 0, 0, -1));
		chk({o_wr_en, o_status.paused, o_status.done}, 3'b010);
		step(fa(1, 0, 0, 0, -1));
		chk({o_wr_en, o_status.paused}, 2'b10);
		step(fa(0, 1, 0, 0, -1));
		idle();
		i_stop = 1'b1;
		@(negedge i_sys_clk);
		i_stop = 1'b0;
		chk({o_status.done, o_status.triggered, o_status.running}, 3'b110);
		$display("test pause done");
	endtask

	task t_preset;
		i_cfg.qual_state = 1'b0;
		for (int p = 0; p < 3; p++) begin
			i_cfg.pos_rt = lac_pos_t'(p);
			arm();
			step(fa(0, 0, 1, 0, -1));
			chk({o_wr_en, o_status.trig_index}, {1'b1, 17'(exp_idx[p])});
			idle();
		end
		$display("test preset done");
	endtask

	task t_segment;
		i_cfg.qual_state = 1'b1;
		i_cfg.segmented = 1'b1;
		i_cfg.pos_rt = LAC_POS_CENTER;
		arm();
		step(fa(0, 0, 0, 1, 4));
		chk(o_status.trig_index, 12);
		repeat (5) begin
			step(fa(0, 1, 0, 0, -1));
			chk(o_wr_en, 1);
		end
		step(fa(0, 0, 0, 1, -1));
		chk(o_status.trig_index, 8);
		idle();
		$display("test segment done");
	endtask

	task t_resources;
		i_cfg = '0;
		arm();
		nx = '0;
		nx.ctr_inc = 2'b01;
		nx.ctr_dec = 2'b10;
		nx.flag_set = 4'h1;
		nx.goto_en = 1'b1;
		nx.goto_state = 4'h5;
		repeat (3) step(nx);
		chk({o_ctr[0], o_status.flags, o_status.flow_state}, {16'h0003, 4'h1, 4'h5});
		chk(o_ctr[1], 16'hfffd);
		idle();
		arm();
		chk({o_ctr[0], o_status.flags, o_status.flow_state}, 24'h0);
		chk(o_ctr[1], 16'h0000);
		idle();
		$display("test resources done");
	endtask

	task t_powerup;
		i_cfg.pu_en = 1'b1;
		i_cfg.pos_pu = LAC_POS_PREMOST;
		i_cfg.pos_rt = LAC_POS_POSTMOST;
		do_reset();
		@(negedge i_sys_clk);
		chk({o_status.running, o_status.pu_run}, 2'b11);
		step(fa(0, 0, 1, 0, -1));
		chk(o_status.trig_index, 57);
		idle();
		$display("test powerup done");
	endtask

	task print_verdict;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole run is about 55 cycles; the 5000-cycle limit leaves ample margin
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end

	initial begin
		i_cfg = '0;
		i_act = '0;
		i_arm = 1'b0;
		i_stop = 1'b0;
		go = 1'b0;
		mismatches = 0;
		comparisons = 0;
		do_reset();
		@(negedge i_sys_clk);
		t_walk();
		t_pause();
		t_preset();
		t_segment();
		t_resources();
		t_powerup();
		print_verdict();
	end
endmodule // lac_top_tb
`default_nettype wire
